// [dcbh_handler.sv]
/*
   Drive control block handler: fetches a block by DMA, decodes command and options,
   hands the disk operation to the engine, tallies retries and errors, writes results back.
   Assumes a word-wide bus master handshake and a disk engine reporting results per attempt.
*/
// Function
// - Command code is word 00 upper byte; main status goes to its lower byte.
// - Decode the eleven defined command codes.
// - Main status written only at completion, before the completion interrupt.
// - Main status codes 0, 1, 2, 6, 10 plus record-processing failure code.
// - Extended status bits are ORed in and kept for the command.
// - Extended status cleared to zero when a command starts.
// - Extended status bit positions as defined for each error.
// - Retry limit applies per command; zero means no retries.
// - Bus error or overrun aborts at once without retry.
// - Identifier search lasts 16 revolutions per attempt.
// - Actual retries byte accumulates over all sectors.
// - DMA count sets operands per bus tenure, zero means one.
// - 31-bit buffer address counter loaded from the block.
// - Requested length sets transfer total; zero means seek only.
// - Option bits 1-0 select the track format.
// - Option bits 4-3 select the check polynomial.
// - Deleted handling for reads except record processing; retries search afresh.
// - Check remainder written back aligned to the top byte of its field.
// - Starting cylinder, head and sector come from words 08 and 09.
// - Block accesses go through own DMA with bus arbitration.
`timescale 1ns/1ps
module dcbh_handler (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Command start and completion.
   input wire logic start_i,
   input wire logic [30:0] block_addr_i,
   input wire logic busy_cleared_i,
   output logic busy_o,
   output logic done_irq_o,
   // Bus master port.
   output logic bus_req_o,
   input wire logic bus_grant_i,
   output logic mem_valid_o,
   output logic mem_write_o,
   output logic [30:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   input wire logic mem_ack_i,
   input wire logic mem_err_i,
   input wire logic [15:0] mem_rdata_i,
   // Disk engine port.
   input wire logic drive_ready_i,
   output logic op_start_o,
   output logic [7:0] op_cmd_o,
   output logic [1:0] op_format_o,
   output logic [1:0] op_poly_o,
   output logic op_hard_sector_o,
   output logic op_fresh_search_o,
   output logic [15:0] op_cylinder_o,
   output logic [7:0] op_head_o,
   output logic [7:0] op_sector_o,
   output logic [15:0] op_length_o,
   output logic [30:0] op_buf_addr_o,
   output logic [4:0] op_burst_o,
   output logic [4:0] op_id_revs_o,
   input wire logic op_done_i,
   input wire logic op_fail_i,
   input wire logic op_fatal_i,
   input wire logic op_deleted_i,
   input wire logic op_record_fail_i,
   input wire logic [15:0] op_errors_i,
   input wire logic [15:0] op_bytes_i,
   input wire logic [47:0] op_remainder_i
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_FETCH = 3'b001, S_DECODE = 3'b011, S_RUN = 3'b010,
      S_WAIT = 3'b110, S_WBACK = 3'b111, S_IRQ = 3'b101
   } dcbh_state_type;

   // Defined command code test.
   function automatic logic dcbh_valid_cmd(input logic [7:0] c);
      dcbh_valid_cmd = (c == dcbh_pkg::WRITE_MULTI_SECTOR_CMD)
         || (c == dcbh_pkg::WRITE_DELETED_CMD)
         || (c == dcbh_pkg::VERIFY_CMD) || (c == dcbh_pkg::READ_MULTI_SECTOR_CMD)
         || (c == dcbh_pkg::RECORD_PROCESSING_CMD) || (c == dcbh_pkg::TRANSPARENT_READ_CMD)
         || (c == dcbh_pkg::READ_IDENTIFIER_CMD) || (c == dcbh_pkg::FORMAT_TRACK_CMD)
         || (c == dcbh_pkg::RECALIBRATE_CMD) || (c == dcbh_pkg::DIAGNOSTIC_CMD)
         || (c == dcbh_pkg::CORRECT_DATA_CMD);
   endfunction

   // Read command test for deleted-data handling.
   function automatic logic dcbh_is_read(input logic [7:0] c);
      dcbh_is_read = (c == dcbh_pkg::READ_MULTI_SECTOR_CMD) || (c == dcbh_pkg::VERIFY_CMD)
         || (c == dcbh_pkg::TRANSPARENT_READ_CMD) || (c == dcbh_pkg::CORRECT_DATA_CMD);
   endfunction

   dcbh_state_type state_q, state_d;
   logic [30:0] base_q, base_d;
   logic [3:0] idx_q, idx_d;
   logic [15:0] w_q [0:9];
   logic [15:0] w_d [0:9];
   logic [15:0] xst_q, xst_d;
   logic [7:0] mst_q, mst_d;
   logic [7:0] retries_q, retries_d;
   logic [15:0] bytes_q, bytes_d;
   logic [47:0] rem_q, rem_d;
   logic pend_q, pend_d;
   logic [2:0] wb_q, wb_d;
   logic sync1_q, sync2_q;
   logic mem_wr_en;
   logic [15:0] mem_rd;
   logic [7:0] cmd;
   logic [7:0] opts;
   logic [7:0] max_retries;
   logic [4:0] burst;
   logic [30:0] wb_addr;
   logic [15:0] wb_data;
   logic del_end;

   // The busy level arrives from the host domain and is synchronised first.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= busy_cleared_i;
         sync2_q <= sync1_q;
      end
   end

   assign cmd = w_q[0][15:8];
   assign max_retries = w_q[2][15:8];
   assign opts = w_q[3][7:0];
   // Burst of zero moves one operand, otherwise the count up to sixteen.
   assign burst = (w_q[3][15:8] == 8'h00) ? 5'h01 :
      ((w_q[3][15:8] > 8'h10) ? dcbh_pkg::DMA_MAX_BURST : w_q[3][12:8]);

   // Shadow copy of the fetched words.
   dcbh_word_mem u_mem (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .wr_en_i(mem_wr_en),
      .wr_addr_i(idx_q),
      .wr_data_i(mem_rdata_i),
      .rd_addr_i(idx_q),
      .rd_data_o(mem_rd)
   );

   // Write-back address and data select: status word, extended, retries, bytes, remainder.
   always_comb begin
      wb_addr = base_q + {25'h0, dcbh_pkg::WORD_CMD_STATUS};
      wb_data = {cmd, mst_q};
      case (wb_q)
         3'h1: begin
            wb_addr = base_q + {25'h0, dcbh_pkg::WORD_EXT_STATUS};
            wb_data = xst_q;
         end
         3'h2: begin
            wb_addr = base_q + {25'h0, dcbh_pkg::WORD_RETRIES};
            wb_data = {max_retries, retries_q};
         end
         3'h3: begin
            wb_addr = base_q + {25'h0, dcbh_pkg::WORD_BYTES_DONE};
            wb_data = bytes_q;
         end
         3'h4: begin
            wb_addr = base_q + {25'h0, dcbh_pkg::WORD_REMAINDER};
            wb_data = rem_q[47:32];
         end
         3'h5: begin
            wb_addr = base_q + {25'h0, dcbh_pkg::WORD_REMAINDER} + 31'd1;
            wb_data = rem_q[31:16];
         end
         3'h6: begin
            wb_addr = base_q + {25'h0, dcbh_pkg::WORD_REMAINDER} + 31'd2;
            wb_data = rem_q[15:0];
         end
         default: begin
            wb_addr = base_q + {25'h0, dcbh_pkg::WORD_CMD_STATUS};
            wb_data = {cmd, mst_q};
         end
      endcase
   end

   // Next-state logic for the command sequencer.
   always_comb begin
      state_d = state_q;
      base_d = base_q;
      idx_d = idx_q;
      w_d = w_q;
      xst_d = xst_q;
      mst_d = mst_q;
      retries_d = retries_q;
      bytes_d = bytes_q;
      rem_d = rem_q;
      pend_d = 1'b0;
      wb_d = wb_q;
      mem_wr_en = 1'b0;
      case (state_q)
         S_IDLE: begin
            if (start_i) begin
               base_d = block_addr_i;
               idx_d = 4'h0;
               xst_d = dcbh_pkg::XST_RESET;
               retries_d = 8'h00;
               bytes_d = 16'h0000;
               rem_d = 48'h0;
               state_d = S_FETCH;
            end
         end
         S_FETCH: begin
            if (bus_grant_i && mem_err_i) begin
               xst_d[dcbh_pkg::XST_BUS_ERROR] = 1'b1;
               mst_d = dcbh_pkg::MST_IRRECOVERABLE;
               wb_d = 3'h0;
               state_d = S_WBACK;
            end else if (bus_grant_i && mem_ack_i) begin
               w_d[idx_q] = mem_rdata_i;
               mem_wr_en = 1'b1;
               if (idx_q == 4'(dcbh_pkg::FETCH_WORDS - 6'h01)) begin
                  state_d = S_DECODE;
               end else begin
                  idx_d = idx_q + 4'h1;
               end
            end
         end
         S_DECODE: begin
            wb_d = 3'h0;
            if (!dcbh_valid_cmd(cmd)) begin
               mst_d = dcbh_pkg::MST_REJECTED;
               state_d = S_WBACK;
            end else if (!drive_ready_i) begin
               mst_d = dcbh_pkg::MST_NOT_READY;
               state_d = S_WBACK;
            end else begin
               pend_d = 1'b1;
               state_d = S_RUN;
            end
         end
         S_RUN: begin
            state_d = S_WAIT;
         end
         S_WAIT: begin
            if (sync2_q) begin
               mst_d = dcbh_pkg::MST_ABORTED;
               state_d = S_WBACK;
            end else if (op_done_i || op_fail_i || op_fatal_i) begin
               xst_d = xst_q | op_errors_i;
               bytes_d = op_bytes_i;
               rem_d = op_remainder_i;
               if (op_fatal_i) begin
                  mst_d = dcbh_pkg::MST_IRRECOVERABLE;
                  state_d = S_WBACK;
               end else if (del_end) begin
                  mst_d = dcbh_pkg::MST_OK;
                  state_d = S_WBACK;
               end else if (op_fail_i && retries_q < max_retries) begin
                  retries_d = retries_q + 8'h01;
                  pend_d = 1'b1;
                  state_d = S_RUN;
               end else if (op_fail_i) begin
                  mst_d = op_record_fail_i ? dcbh_pkg::MST_RECORD_FAIL
                     : dcbh_pkg::MST_IRRECOVERABLE;
                  state_d = S_WBACK;
               end else begin
                  mst_d = dcbh_pkg::MST_OK;
                  state_d = S_WBACK;
               end
            end
         end
         S_WBACK: begin
            if (bus_grant_i && (mem_ack_i || mem_err_i)) begin
               if (mem_err_i) begin
                  xst_d[dcbh_pkg::XST_BUS_ERROR] = 1'b1;
               end
               if (wb_q == 3'h6) begin
                  state_d = S_IRQ;
               end else begin
                  wb_d = wb_q + 3'h1;
               end
            end
         end
         S_IRQ: begin
            state_d = S_IDLE;
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= S_IDLE;
         base_q <= 31'h0;
         idx_q <= 4'h0;
         for (int i = 0; i < 10; i++) begin
            w_q[i] <= 16'h0000;
         end
         xst_q <= dcbh_pkg::XST_RESET;
         mst_q <= dcbh_pkg::MST_OK;
         retries_q <= 8'h00;
         bytes_q <= 16'h0000;
         rem_q <= 48'h0;
         pend_q <= 1'b0;
         wb_q <= 3'h0;
      end else begin
         state_q <= state_d;
         base_q <= base_d;
         idx_q <= idx_d;
         w_q <= w_d;
         xst_q <= xst_d;
         mst_q <= mst_d;
         retries_q <= retries_d;
         bytes_q <= bytes_d;
         rem_q <= rem_d;
         pend_q <= pend_d;
         wb_q <= wb_d;
      end
   end

   // Bus master outputs: request held for fetch and write-back.
   assign bus_req_o = (state_q == S_FETCH) || (state_q == S_WBACK);
   assign mem_valid_o = bus_req_o && bus_grant_i;
   assign mem_write_o = (state_q == S_WBACK);
   assign mem_addr_o = (state_q == S_WBACK) ? wb_addr : base_q + {27'h0, idx_q};
   assign mem_wdata_o = wb_data;
   assign busy_o = (state_q != S_IDLE);
   assign done_irq_o = (state_q == S_IRQ);

   // Operation parameters presented to the disk engine.
   assign op_start_o = pend_q;
   assign op_cmd_o = cmd;
   assign op_format_o = opts[dcbh_pkg::OPT_FORMAT_LSB +: 2];
   assign op_poly_o = opts[dcbh_pkg::OPT_POLY_LSB +: 2];
   assign op_hard_sector_o = opts[dcbh_pkg::OPT_HARD_SECTOR_BIT];
   // A retry of a read that may meet a deleted sector begins with a new search.
   assign op_fresh_search_o = dcbh_is_read(cmd) && (retries_q != 8'h00);
   assign op_cylinder_o = w_q[8];
   assign op_head_o = w_q[9][15:8];
   assign op_sector_o = w_q[9][7:0];
   assign op_length_o = w_q[6];
   assign op_buf_addr_o = {w_q[4][14:0], w_q[5]};
   assign op_burst_o = burst;
   assign op_id_revs_o = dcbh_pkg::ID_SEARCH_REVS;

   // A deleted sector on a read ends the command when delivery is chosen.
   assign del_end = op_deleted_i && opts[dcbh_pkg::OPT_DELETED_BIT] && dcbh_is_read(cmd);
   // The shadow copy is only kept for inspection.
   logic unused_sig;
   assign unused_sig = |mem_rd;

   AST_IRQ_AFTER_STATUS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      done_irq_o |-> $past(state_q) == S_WBACK)
      else $error("Interrupt without prior status write.");
   AST_REJECT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == S_DECODE && !dcbh_valid_cmd(cmd)) |=> mst_q == dcbh_pkg::MST_REJECTED)
      else $error("Undefined command not rejected.");
   AST_XST_CLEAR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == S_IDLE && start_i) |=> xst_q == 16'h0000)
      else $error("Extended status not cleared at start.");
   AST_XST_STICKY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ((state_q != S_IDLE) && $past(state_q) != S_IDLE) |-> ($past(xst_q) & ~xst_q) == 16'h0000)
      else $error("Extended status bit dropped.");
   AST_RETRY_LIMIT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      retries_q <= max_retries || state_q == S_IDLE || state_q == S_FETCH)
      else $error("Retries exceed limit.");
   AST_FATAL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == S_WAIT && op_fatal_i && !sync2_q) |=> state_q == S_WBACK)
      else $error("Fatal error retried.");
   AST_BURST: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      burst >= 5'h01 && burst <= 5'h10)
      else $error("Burst out of range.");
   AST_STATUS_WORD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state_q == S_WBACK && wb_q == 3'h0) |-> mem_wdata_o == {cmd, mst_q})
      else $error("Status word layout wrong.");
   COV_OK: cover property (@(posedge clock_i) done_irq_o && mst_q == dcbh_pkg::MST_OK);
   COV_RETRY: cover property (@(posedge clock_i)
      state_q == S_WAIT && op_fail_i ##1 state_q == S_RUN);
   COV_REJ: cover property (@(posedge clock_i) done_irq_o && mst_q == dcbh_pkg::MST_REJECTED);
endmodule // dcbh_handler

// [dcbh_pkg.sv]
/*
   Package for the drive control block handler: word offsets of the block, command codes,
   main and extended status codes, option fields and timing counts.
   Assumes nothing of its surroundings; used only by the handler, with full scoping.
*/
package dcbh_pkg;
   // Word offsets within a drive control block.
   localparam logic [5:0] WORD_CMD_STATUS = 6'h00;
   localparam logic [5:0] WORD_EXT_STATUS = 6'h01;
   localparam logic [5:0] WORD_RETRIES = 6'h02;
   localparam logic [5:0] WORD_DMA_OPTIONS = 6'h03;
   localparam logic [5:0] WORD_BUF_ADDR_HI = 6'h04;
   localparam logic [5:0] WORD_BUF_ADDR_LO = 6'h05;
   localparam logic [5:0] WORD_BUF_LENGTH = 6'h06;
   localparam logic [5:0] WORD_BYTES_DONE = 6'h07;
   localparam logic [5:0] WORD_CYLINDER = 6'h08;
   localparam logic [5:0] WORD_HEAD_SECTOR = 6'h09;
   localparam logic [5:0] WORD_REMAINDER = 6'h1D;
   localparam logic [5:0] REMAINDER_WORDS = 6'h03;
   localparam logic [5:0] FETCH_WORDS = 6'h0A;

   // Command codes.
   localparam logic [7:0] WRITE_MULTI_SECTOR_CMD = 8'h00;
   localparam logic [7:0] WRITE_DELETED_CMD = 8'h01;
   localparam logic [7:0] VERIFY_CMD = 8'h10;
   localparam logic [7:0] READ_MULTI_SECTOR_CMD = 8'h11;
   localparam logic [7:0] RECORD_PROCESSING_CMD = 8'h12;
   localparam logic [7:0] TRANSPARENT_READ_CMD = 8'h13;
   localparam logic [7:0] READ_IDENTIFIER_CMD = 8'h20;
   localparam logic [7:0] FORMAT_TRACK_CMD = 8'h40;
   localparam logic [7:0] RECALIBRATE_CMD = 8'h41;
   localparam logic [7:0] DIAGNOSTIC_CMD = 8'h80;
   localparam logic [7:0] CORRECT_DATA_CMD = 8'h81;

   // Main status codes.
   localparam logic [7:0] MST_OK = 8'h00;
   localparam logic [7:0] MST_IRRECOVERABLE = 8'h01;
   localparam logic [7:0] MST_NOT_READY = 8'h02;
   localparam logic [7:0] MST_RECORD_FAIL = 8'h03;
   localparam logic [7:0] MST_REJECTED = 8'h06;
   localparam logic [7:0] MST_ABORTED = 8'h0A;

   // Extended status bit positions.
   localparam int XST_WRITE_FAULT = 0;
   localparam int XST_CHECK_ERROR = 1;
   localparam int XST_OVERRUN = 2;
   localparam int XST_NO_ID = 3;
   localparam int XST_DELETED = 4 + 1;
   localparam int XST_WRITE_PROT = 6;
   localparam int XST_POSITIONING = 7;
   localparam int XST_DATA_TIMEOUT = 8;
   localparam int XST_UNCORRECTABLE = 10;
   localparam int XST_POS_TIMEOUT = 13;
   localparam int XST_BUS_ERROR = 15;
   localparam logic [15:0] XST_RESET = 16'h0000;

   // Option field positions.
   localparam int OPT_FORMAT_LSB = 0;
   localparam int OPT_POLY_LSB = 3;
   localparam int OPT_DELETED_BIT = 5;
   localparam int OPT_HARD_SECTOR_BIT = 7;

   // Longest burst and identifier search limit.
   localparam logic [4:0] DMA_MAX_BURST = 5'h10;
   localparam logic [4:0] ID_SEARCH_REVS = 5'h10;
endpackage

// [dcbh_word_mem.sv]
/*
   Small memory for the fetched control block words, with registered read data.
   Assumes one clock and an active low asynchronous reset; one write and one read port.
*/
`timescale 1ns/1ps
module dcbh_word_mem (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Write port.
   input wire logic wr_en_i,
   input wire logic [3:0] wr_addr_i,
   input wire logic [15:0] wr_data_i,
   // Read port.
   input wire logic [3:0] rd_addr_i,
   output logic [15:0] rd_data_o
);
   logic [15:0] mem_q [0:15];
   logic [15:0] rd_data_q;

   // Storage is written without reset; read data are registered.
   always_ff @(posedge clock_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end

   // Registered read port.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_q <= 16'h0000;
      end else begin
         rd_data_q <= mem_q[rd_addr_i];
      end
   end

   assign rd_data_o = rd_data_q;
endmodule // dcbh_word_mem

// [dcbh_host_mem.sv]
/*
   Host memory model on the far side of the handler's bus master port.
   Assumes one clock, an active low reset and control blocks below word address 256.
*/
`timescale 1ns/1ps
module dcbh_host_mem (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Bus port.
   input wire logic bus_req_i,
   output logic bus_grant_o,
   input wire logic mem_valid_i,
   input wire logic mem_write_i,
   input wire logic [30:0] mem_addr_i,
   input wire logic [15:0] mem_wdata_i,
   output logic mem_ack_o,
   output logic mem_err_o,
   output logic [15:0] mem_rdata_o,
   // Wait cycles before each answer.
   input wire logic [1:0] slow_i
);
   logic [15:0] mem [0:255];
   logic [1:0] wait_q;

   // This model never reports a bus fault.
   assign mem_err_o = 1'b0;

   // Grant one cycle after request; each beat answered after slow_i waits.
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_grant_o <= 1'b0;
         mem_ack_o <= 1'b0;
         wait_q <= 2'h0;
         mem_rdata_o <= 16'h5A5A;
      end else begin
         bus_grant_o <= bus_req_i;
         mem_rdata_o <= ~mem_rdata_o; // Stale data never holds its last value.
         if (mem_ack_o || !(mem_valid_i && bus_grant_o)) begin
            mem_ack_o <= 1'b0;
            wait_q <= slow_i;
         end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
         end else begin
            mem_ack_o <= 1'b1;
            // Only the low byte is decoded; the host keeps blocks in range.
            if (mem_write_i) begin
               mem[mem_addr_i[7:0]] <= mem_wdata_i;
            end else begin
               mem_rdata_o <= mem[mem_addr_i[7:0]];
            end
         end
      end
   end
endmodule // dcbh_host_mem

// [disk_command_block_handler_test.sv]
/*
   Self-checking testbench for the drive control block handler.
   Assumes the host memory model as bus partner; the bench plays the disk engine.
*/
`timescale 1ns/1ps
module disk_command_block_handler_test;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic start_i = 1'b0;
   logic busy_cleared_i = 1'b0;
   logic drive_ready_i = 1'b1;
   logic op_deleted_i = 1'b0;
   logic op_done_i = 1'b0;
   logic op_fail_i = 1'b0;
   logic op_fatal_i = 1'b0;
   logic [30:0] block_addr_i = 31'h00000040;
   logic [15:0] op_errors_i = 16'h0000;
   logic [1:0] mem_slow = 2'h0;
   logic busy_o, done_irq_o, bus_req_o, bus_grant_i, mem_valid_o, mem_write_o;
   logic mem_ack_i, mem_err_i, op_start_o, op_hard_sector_o, op_fresh_search_o;
   logic [30:0] mem_addr_o, op_buf_addr_o;
   logic [15:0] mem_wdata_o, mem_rdata_i, op_cylinder_o, op_length_o;
   logic [7:0] op_cmd_o, op_head_o, op_sector_o;
   logic [1:0] op_format_o, op_poly_o;
   logic [4:0] op_burst_o, op_id_revs_o;
   int n_fail = 0;
   int checks = 0;
   int starts = 0;

   // Free-running 100 MHz clock.
   always #5 clock_i = ~clock_i;

   dcbh_handler i_dcbh_handler (.clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i),
      .block_addr_i(block_addr_i), .busy_cleared_i(busy_cleared_i), .busy_o(busy_o),
      .done_irq_o(done_irq_o), .bus_req_o(bus_req_o), .bus_grant_i(bus_grant_i),
      .mem_valid_o(mem_valid_o), .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_err_i(mem_err_i),
      .mem_rdata_i(mem_rdata_i), .drive_ready_i(drive_ready_i), .op_start_o(op_start_o),
      .op_cmd_o(op_cmd_o), .op_format_o(op_format_o), .op_poly_o(op_poly_o),
      .op_hard_sector_o(op_hard_sector_o), .op_fresh_search_o(op_fresh_search_o),
      .op_cylinder_o(op_cylinder_o),
      .op_head_o(op_head_o), .op_sector_o(op_sector_o), .op_length_o(op_length_o),
      .op_buf_addr_o(op_buf_addr_o), .op_burst_o(op_burst_o), .op_id_revs_o(op_id_revs_o),
      .op_done_i(op_done_i), .op_fail_i(op_fail_i), .op_fatal_i(op_fatal_i),
      .op_deleted_i(op_deleted_i), .op_record_fail_i(1'b0), .op_errors_i(op_errors_i),
      .op_bytes_i(16'h0200), .op_remainder_i(48'h123456789ABC));

   dcbh_host_mem i_dcbh_host_mem (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_o),
      .bus_grant_o(bus_grant_i), .mem_valid_i(mem_valid_o), .mem_write_i(mem_write_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
      .mem_err_o(mem_err_i), .mem_rdata_o(mem_rdata_i), .slow_i(mem_slow));

   // Prints the counts and the verdict, then stops.
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Compares one value and counts it.
   task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // Loads a block, starts it and plays the engine by mode: 0 gives nfail failed attempts
   // then success, 1 a fatal error at once, 2 host clears busy.
   task automatic run(input logic [7:0] cmd, input logic [7:0] maxr, input logic [7:0] dma,
                      input logic [7:0] opt, input int nfail, input int mode);
      int n;
      int w;
      bit fin;
      i_dcbh_host_mem.mem[8'h40] = {cmd, 8'hEE};
      i_dcbh_host_mem.mem[8'h41] = 16'hFFFF;
      i_dcbh_host_mem.mem[8'h42] = {maxr, 8'h33};
      i_dcbh_host_mem.mem[8'h43] = {dma, opt};
      i_dcbh_host_mem.mem[8'h44] = 16'h8001;
      i_dcbh_host_mem.mem[8'h45] = 16'h2345;
      i_dcbh_host_mem.mem[8'h46] = 16'h0400;
      i_dcbh_host_mem.mem[8'h48] = 16'h0123;
      i_dcbh_host_mem.mem[8'h49] = 16'h0407;
      starts = 0;
      w = 0;
      fin = 1'b0;
      start_i = 1'b1;
      @(posedge clock_i);
      #1;
      start_i = 1'b0;
      for (n = 0; n < 3000 && !fin; n++) begin
         @(posedge clock_i);
         #1;
         op_done_i = 1'b0;
         op_fail_i = 1'b0;
         op_fatal_i = 1'b0;
         fin = (done_irq_o === 1'b1);
         if (op_start_o === 1'b1) begin
            starts++;
            w = 3;
         end else if (w > 0) begin
            w--;
            if (w == 0 && mode == 2) begin
               busy_cleared_i = 1'b1;
            end else if (w == 0) begin
               op_errors_i = (mode == 1) ? 16'h0004 : (starts <= nfail) ? 16'h0002 : 16'h0020;
               op_fatal_i = (mode == 1);
               op_fail_i = (mode == 0 && starts <= nfail);
               op_done_i = (mode == 0 && starts > nfail);
            end
         end
      end
      busy_cleared_i = 1'b0;
      if (!fin) begin
         n_fail++;
         tally_and_finish();
      end
   endtask

   // Judges the written-back status, extended and retry words, the engine attempts and the return to idle.
   task automatic expect_result(input logic [7:0] cmd, input logic [7:0] mst,
                                input logic [7:0] maxr, input logic [7:0] act,
                                input logic [15:0] ext, input int n_starts);
      check(i_dcbh_host_mem.mem[8'h40], {cmd, mst}, "main status");
      check(i_dcbh_host_mem.mem[8'h41], ext, "extended status");
      check(i_dcbh_host_mem.mem[8'h42], {maxr, act}, "retry bytes");
      check(starts, n_starts, "engine attempts");
      @(posedge clock_i);
      #1;
      check(busy_o, 1'b0, "busy after completion");
   endtask

   // Read with one retry and every option field set.
   task automatic s_read_retry;
      run(8'h11, 8'h02, 8'h00, 8'hB3, 1, 0);
      expect_result(8'h11, 8'h00, 8'h02, 8'h01, 16'h0022, 2);
      check(op_format_o, 2'h3, "format");
      check(op_poly_o, 2'h2, "polynomial");
      check(op_hard_sector_o, 1'b1, "hard sector");
      check(op_burst_o, 5'h01, "zero burst");
      check(op_buf_addr_o, 31'h00012345, "buffer address");
      check({op_cylinder_o, op_head_o, op_sector_o}, 32'h01230407, "start sector");
      check(op_length_o, 16'h0400, "length");
      check(op_id_revs_o, 5'h10, "search revolutions");
      check(op_fresh_search_o, 1'b1, "fresh search");
      check(i_dcbh_host_mem.mem[8'h47], 16'h0200, "bytes done");
      check({i_dcbh_host_mem.mem[8'h5D], i_dcbh_host_mem.mem[8'h5E],
             i_dcbh_host_mem.mem[8'h5F]}, 48'h123456789ABC, "remainder");
   endtask

   // Zero limit, fatal error, undefined code, drive not ready, host abort.
   task automatic s_errors;
      run(8'h00, 8'h00, 8'h05, 8'h00, 1, 0);
      expect_result(8'h00, 8'h01, 8'h00, 8'h00, 16'h0002, 1);
      check(op_burst_o, 5'h05, "burst five");
      run(8'h10, 8'h03, 8'h10, 8'h08, 0, 1);
      expect_result(8'h10, 8'h01, 8'h03, 8'h00, 16'h0004, 1);
      check(op_burst_o, 5'h10, "burst sixteen");
      check(op_poly_o, 2'h1, "polynomial");
      run(8'h55, 8'h01, 8'h01, 8'h00, 0, 0);
      expect_result(8'h55, 8'h06, 8'h01, 8'h00, 16'h0000, 0);
      drive_ready_i = 1'b0;
      run(8'h11, 8'h01, 8'h01, 8'h00, 0, 0);
      expect_result(8'h11, 8'h02, 8'h01, 8'h00, 16'h0000, 0);
      drive_ready_i = 1'b1;
      op_deleted_i = 1'b1;
      run(8'h11, 8'h02, 8'h01, 8'h20, 1, 0);
      expect_result(8'h11, 8'h00, 8'h02, 8'h00, 16'h0002, 1);
      check(op_fresh_search_o, 1'b0, "first search");
      run(8'h11, 8'h02, 8'h01, 8'h00, 1, 0);
      expect_result(8'h11, 8'h00, 8'h02, 8'h01, 16'h0022, 2);
      op_deleted_i = 1'b0;
      run(8'h13, 8'h00, 8'h01, 8'h00, 0, 2);
      expect_result(8'h13, 8'h0A, 8'h00, 8'h00, 16'h0000, 1);
   endtask

   // Every defined code reaches the engine, with slow memory on some.
   task automatic s_all_codes;
      logic [7:0] codes [0:10];
      codes = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h40, 8'h41, 8'h80, 8'h81};
      for (int k = 0; k < 11; k++) begin
         mem_slow = k[1:0];
         run(codes[k], 8'h00, 8'h01, {6'h00, k[1:0]}, 0, 0);
         expect_result(codes[k], 8'h00, 8'h00, 8'h00, 16'h0020, 1);
         check(op_cmd_o, codes[k], "command code");
         check(op_format_o, k[1:0], "format");
      end
      mem_slow = 2'h0;
   endtask

   // Reset, scenarios, verdict.
   initial begin
      repeat (2) @(posedge clock_i);
      #1;
      rst_n_i = 1'b1;
      check(busy_o, 1'b0, "idle after reset");
      s_read_retry();
      s_errors();
      s_all_codes();
      tally_and_finish();
   end
endmodule // disk_command_block_handler_test
